// ===== src/csp_pkg.sv
// constants, field layout and state type for the buffered clocked serial port
package csp_pkg;

	// register byte offsets on the Avalon-MM slave
	localparam logic [5:0] CSP_OFS_BUF_BASE = 6'h00;
	localparam logic [5:0] CSP_OFS_BUF_LAST = 6'h1C;
	localparam logic [5:0] CSP_OFS_CTRL_ONE = 6'h20;
	localparam logic [5:0] CSP_OFS_CTRL_TWO = 6'h24;
	localparam logic [5:0] CSP_OFS_STATUS = 6'h28;

	// serial_control_one fields
	localparam int CSP_C1_RUN = 7;
	localparam int CSP_C1_ABORT = 6;
	localparam int CSP_C1_MODE_HI = 5;
	localparam int CSP_C1_MODE_LO = 3;
	localparam int CSP_C1_CLK_HI = 2;
	localparam int CSP_C1_CLK_LO = 0;

	// serial_control_two fields
	localparam int CSP_C2_LOWRATE = 4;
	localparam int CSP_C2_COUNT_HI = 2;
	localparam int CSP_C2_COUNT_LO = 0;

	// serial_status_reg fields
	localparam int CSP_ST_ACTIVE = 7;
	localparam int CSP_ST_SHIFT = 6;
	localparam int CSP_ST_WAIT = 5;

	// transfer_mode_select codes
	localparam logic [2:0] CSP_MODE_TX8 = 3'h0;
	localparam logic [2:0] CSP_MODE_TX4 = 3'h2;
	localparam logic [2:0] CSP_MODE_RX8 = 3'h5;
	localparam logic [2:0] CSP_MODE_RX4 = 3'h6;

	// clock select codes
	localparam logic [2:0] CSP_CLK_DIV13 = 3'h0;
	localparam logic [2:0] CSP_CLK_DIV8 = 3'h1;
	localparam logic [2:0] CSP_CLK_DIV7 = 3'h2;
	localparam logic [2:0] CSP_CLK_DIV6 = 3'h3;
	localparam logic [2:0] CSP_CLK_DIV5 = 3'h4;
	localparam logic [2:0] CSP_CLK_DIV4 = 3'h5;
	localparam logic [2:0] CSP_CLK_RSVD = 3'h6;
	localparam logic [2:0] CSP_CLK_EXT = 3'h7;

	// half periods of the internal serial clock, in clk_sys cycles (divide by 2^n)
	localparam logic [15:0] CSP_HALF_DIV13 = 16'h1000;
	localparam logic [15:0] CSP_HALF_DIV8 = 16'h0080;
	localparam logic [15:0] CSP_HALF_DIV7 = 16'h0040;
	localparam logic [15:0] CSP_HALF_DIV6 = 16'h0020;
	localparam logic [15:0] CSP_HALF_DIV5 = 16'h0010;
	localparam logic [15:0] CSP_HALF_DIV4 = 16'h0008;

	// low-rate source: fs/2^5 with fs in Hz, half period derived from the 50 MHz clock
	localparam int CSP_CLK_SYS_HZ = 50000000;
	localparam int CSP_LOW_FS_HZ = 32768;
	localparam int CSP_LOW_DIV = 32;
	localparam int CSP_LOW_HALF_CYC = CSP_CLK_SYS_HZ / (CSP_LOW_FS_HZ / CSP_LOW_DIV * 2);

	// word geometry
	localparam logic [2:0] CSP_LAST_BIT8 = 3'h7;
	localparam logic [2:0] CSP_LAST_BIT4 = 3'h3;
	localparam logic [7:0] CSP_NIBBLE_MASK = 8'h0F;
	localparam logic [7:0] CSP_DUMMY_WORD = 8'hFF;
	localparam int CSP_WORDS = 8;

	// reset values
	localparam logic [7:0] CSP_BUF_RESET = 8'h00;
	localparam logic [2:0] CSP_MODE_RESET = 3'h0;
	localparam logic [2:0] CSP_CLK_RESET = 3'h0;
	localparam logic [2:0] CSP_COUNT_RESET = 3'h0;

	typedef enum logic [1:0] {
		CSP_IDLE = 2'b00,
		CSP_SHIFT = 2'b01,
		CSP_WAIT = 2'b10
	} csp_state_t;

endpackage

// ===== src/csp_top.sv
// buffered clocked serial port with eight-word buffer and Avalon-MM register slave
//
// Summary of operation
// RULE_01: clock code 111 external, 000-101 internal, 110 reserved
// RULE_02: internal clock drives pin, pin high at start
// RULE_03: internal clock pauses when software falls behind
// RULE_04: external clock pulses at least four cycles wide
// RULE_05: transmit data changes on clock pin falling edge
// RULE_06: receive data sampled on clock pin rising edge
// RULE_07: four-bit words use low nibble, upper zeroed
// RULE_08: words shift least significant bit first
// RULE_09: up to eight words, interrupt after count
// RULE_10: software stops port before changing word count
// RULE_11: transmit loads next buffer word at LSB output
// RULE_12: transmit raises buffer-empty interrupt after final bit
// RULE_13: internal transmit waits for data, one write resumes
// RULE_14: any buffer write cancels transmit wait
// RULE_15: run cleared: finish current word then go idle
// RULE_16: abort ends transfer and clears active at once
// RULE_17: external transmit without data sends dummy, ends
// RULE_18: receive stores words, buffer-full interrupt after count
// RULE_19: internal receive waits until buffer read
// RULE_20: external receive overrun drops word and stops
// RULE_21: run cleared stores last word; abort discards
// RULE_22: mode change clears buffer contents
// RULE_23: abort bit clears itself after taking effect
// RULE_24: active flag reads one during transfer
// RULE_25: after reset idle, clock pin high, inactive
`timescale 1ns/1ns
`default_nettype none

module csp_top
	import csp_pkg::*;
#(
	parameter int LOW_RATE_HALF = CSP_LOW_HALF_CYC
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	output logic serial_data_out,
	input wire logic serial_data_in,
	output logic word_block_irq
);

	////////////////////////////////////////////////////////////////////////////
	// register state

	logic [7:0] data_buffer_regs [CSP_WORDS];
	logic run_bit_q;
	logic abort_bit_q;
	logic [2:0] transfer_mode_select_q;
	logic [2:0] clk_sel_q;
	logic [2:0] word_count_q;
	logic low_rate_divider_select_q;
	logic waitreq_q;
	logic [31:0] rdata_q;

	// core state
	csp_state_t state_q;
	logic [2:0] idx_q;
	logic [2:0] bit_q;
	logic [7:0] shift_q;
	logic serviced_q;
	logic owed_q;
	logic last_word_q;
	logic [15:0] div_q;
	logic sck_q;
	logic sck_oe_q;
	logic sck_prev_q;
	logic so_q;
	logic irq_q;

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic wr_acc;
	logic rd_acc;
	logic buf_hit;
	logic wr_buf;
	logic rd_buf;
	logic wr_c1;
	logic wr_c2;
	logic [2:0] new_mode;
	logic mode_ok;
	logic start_ev;

	// a request completes on the edge where waitrequest is low
	assign wr_acc = avs_write && !waitreq_q;
	assign rd_acc = avs_read && !waitreq_q;
	assign buf_hit = avs_address <= CSP_OFS_BUF_LAST;
	assign wr_buf = wr_acc && buf_hit && avs_byteenable[0];
	assign rd_buf = rd_acc && buf_hit;
	assign wr_c1 = wr_acc && (avs_address == CSP_OFS_CTRL_ONE) && avs_byteenable[0];
	assign wr_c2 = wr_acc && (avs_address == CSP_OFS_CTRL_TWO) && avs_byteenable[0];
	assign new_mode = avs_writedata[CSP_C1_MODE_HI:CSP_C1_MODE_LO];
	assign mode_ok = (new_mode == CSP_MODE_TX8) || (new_mode == CSP_MODE_TX4) ||
		(new_mode == CSP_MODE_RX8) || (new_mode == CSP_MODE_RX4);
	// reserved modes and the reserved clock code never start a transfer
	assign start_ev = wr_c1 && avs_writedata[CSP_C1_RUN] && !avs_writedata[CSP_C1_ABORT] &&
		mode_ok && (avs_writedata[CSP_C1_CLK_HI:CSP_C1_CLK_LO] != CSP_CLK_RSVD) &&
		(state_q == CSP_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// mode and timing decode

	logic is_tx;
	logic is_four;
	logic ext_clk;
	logic [2:0] last_bit;
	logic [15:0] half_cnt;
	logic div_term;
	logic fall_ev;
	logic rise_ev;
	logic word_end;
	logic blk_end;
	logic service_ev;
	logic serviced;
	logic rx_drop;
	logic rx_store;
	logic [7:0] tx_word;

	assign is_tx = (transfer_mode_select_q == CSP_MODE_TX8) ||
		(transfer_mode_select_q == CSP_MODE_TX4);
	assign is_four = (transfer_mode_select_q == CSP_MODE_TX4) ||
		(transfer_mode_select_q == CSP_MODE_RX4);
	assign ext_clk = clk_sel_q == CSP_CLK_EXT; // RULE_01
	assign last_bit = is_four ? CSP_LAST_BIT4 : CSP_LAST_BIT8;

	// internal divider rates; the low-rate source only replaces code 000
	always_comb
	begin
		if (clk_sel_q == CSP_CLK_DIV13)
			half_cnt = low_rate_divider_select_q ? 16'(LOW_RATE_HALF) : CSP_HALF_DIV13; // RULE_01
		else if (clk_sel_q == CSP_CLK_DIV8)
			half_cnt = CSP_HALF_DIV8;
		else if (clk_sel_q == CSP_CLK_DIV7)
			half_cnt = CSP_HALF_DIV7;
		else if (clk_sel_q == CSP_CLK_DIV6)
			half_cnt = CSP_HALF_DIV6;
		else if (clk_sel_q == CSP_CLK_DIV5)
			half_cnt = CSP_HALF_DIV5;
		else
			half_cnt = CSP_HALF_DIV4;
	end

	// external pin is taken as synchronous; edges need the pulse to stay a few cycles
	assign div_term = (div_q == half_cnt - 16'h0001);
	assign fall_ev = (state_q == CSP_SHIFT) &&
		(ext_clk ? (sck_prev_q && !serial_clock_pin_in) : (div_term && sck_q)); // RULE_04
	assign rise_ev = (state_q == CSP_SHIFT) &&
		(ext_clk ? (!sck_prev_q && serial_clock_pin_in) : (div_term && !sck_q));
	assign word_end = rise_ev && (bit_q == last_bit) && !abort_bit_q;
	assign blk_end = word_end && (idx_q == word_count_q);

	// a buffer write on transmit or a buffer read on receive counts, in use or not
	assign service_ev = is_tx ? wr_buf : rd_buf; // RULE_14 RULE_19
	// an access in the same cycle as a block end still counts
	assign serviced = serviced_q || service_ev;
	assign rx_drop = word_end && !is_tx && ext_clk && owed_q && !service_ev; // RULE_20
	assign rx_store = word_end && !is_tx && !rx_drop; // RULE_18 RULE_21
	// dummy data replaces the word when an external transmit was never refilled
	assign tx_word = (ext_clk && owed_q && !service_ev) ? CSP_DUMMY_WORD :
		data_buffer_regs[idx_q]; // RULE_17

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle per request

	// waitrequest drops for exactly one cycle after a request appears
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			waitreq_q <= 1'b1;
		else
			waitreq_q <= !((avs_read || avs_write) && waitreq_q);
	end

	// read data is registered in the wait cycle so it stands on the accepting edge
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			rdata_q <= 32'h0000_0000;
		else if (avs_read && waitreq_q)
		begin
			if (buf_hit)
				rdata_q <= {24'h00_0000, data_buffer_regs[avs_address[4:2]]};
			else if (avs_address == CSP_OFS_CTRL_ONE)
				rdata_q <= {24'h00_0000, run_bit_q, abort_bit_q, transfer_mode_select_q, clk_sel_q};
			else if (avs_address == CSP_OFS_CTRL_TWO)
				rdata_q <= {28'h000_0000, low_rate_divider_select_q, word_count_q};
			else if (avs_address == CSP_OFS_STATUS)
				rdata_q <= {24'h00_0000, state_q != CSP_IDLE, state_q == CSP_SHIFT,
					state_q == CSP_WAIT, 5'h00}; // RULE_24
			else
				rdata_q <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers

	// the abort bit lives one cycle, long enough for the core to act on it
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			run_bit_q <= 1'b0;
			abort_bit_q <= 1'b0;
			transfer_mode_select_q <= CSP_MODE_RESET;
			clk_sel_q <= CSP_CLK_RESET;
		end
		else if (wr_c1)
		begin
			run_bit_q <= avs_writedata[CSP_C1_RUN];
			abort_bit_q <= avs_writedata[CSP_C1_ABORT];
			transfer_mode_select_q <= new_mode;
			clk_sel_q <= avs_writedata[CSP_C1_CLK_HI:CSP_C1_CLK_LO];
		end
		else
			abort_bit_q <= 1'b0; // RULE_23
	end

	// word count may be rewritten any time; software keeps it stable while shifting
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			word_count_q <= CSP_COUNT_RESET;
			low_rate_divider_select_q <= 1'b0;
		end
		else if (wr_c2)
		begin
			word_count_q <= avs_writedata[CSP_C2_COUNT_HI:CSP_C2_COUNT_LO]; // RULE_09 RULE_10
			low_rate_divider_select_q <= avs_writedata[CSP_C2_LOWRATE];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data buffer, one entry per word

	genvar gi;
	generate
		for (gi = 0; gi < CSP_WORDS; gi++)
		begin : g_buf
			always_ff @(posedge clk_sys)
			begin
				if (reset)
					data_buffer_regs[gi] <= CSP_BUF_RESET;
				else if (wr_c1 && (new_mode != transfer_mode_select_q))
					data_buffer_regs[gi] <= CSP_BUF_RESET; // RULE_22
				// the last bit is still on the pin at this edge, not yet in shift_q
				else if (rx_store && (idx_q == 3'(gi)))
					data_buffer_regs[gi] <= is_four ? {4'h0, serial_data_in, shift_q[2:0]} :
						{serial_data_in, shift_q[6:0]}; // RULE_07
				else if (wr_buf && (avs_address[4:2] == 3'(gi)))
					data_buffer_regs[gi] <= avs_writedata[7:0];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// internal serial clock generator

	// clock parks high outside shifting, so a wait freezes it high
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			div_q <= 16'h0000;
			sck_q <= 1'b1; // RULE_25
		end
		else if ((state_q == CSP_SHIFT) && !ext_clk && !abort_bit_q)
		begin
			if (div_term)
			begin
				div_q <= 16'h0000;
				sck_q <= !sck_q;
			end
			else
				div_q <= div_q + 16'h0001;
		end
		else
		begin
			div_q <= 16'h0000;
			sck_q <= 1'b1; // RULE_02 RULE_03
		end
	end

	// pin drive follows the clock source; external pins are only watched
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			sck_oe_q <= 1'b0;
			sck_prev_q <= 1'b1;
		end
		else
		begin
			sck_oe_q <= !ext_clk; // RULE_02
			sck_prev_q <= serial_clock_pin_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transfer sequencer

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_q <= CSP_IDLE;
			idx_q <= 3'h0;
			bit_q <= 3'h0;
			last_word_q <= 1'b0;
		end
		else if (abort_bit_q)
			state_q <= CSP_IDLE; // RULE_16 RULE_21
		else
		begin
			case (state_q)
				CSP_IDLE:
				begin
					if (start_ev)
					begin
						state_q <= CSP_SHIFT;
						idx_q <= 3'h0;
						bit_q <= 3'h0;
						last_word_q <= 1'b0;
					end
				end
				CSP_SHIFT:
				begin
					if (word_end)
					begin
						bit_q <= 3'h0;
						idx_q <= blk_end ? 3'h0 : idx_q + 3'h1; // RULE_09
						if (rx_drop || last_word_q || !run_bit_q)
							state_q <= CSP_IDLE; // RULE_15 RULE_17 RULE_20 RULE_21
						else if (blk_end && !serviced && !ext_clk)
							state_q <= CSP_WAIT; // RULE_03 RULE_13 RULE_19
					end
					else if (rise_ev)
						bit_q <= bit_q + 3'h1;
					if (fall_ev && is_tx && (bit_q == 3'h0) && ext_clk && owed_q && !service_ev)
						last_word_q <= 1'b1; // RULE_17
				end
				CSP_WAIT:
				begin
					if (!run_bit_q)
						state_q <= CSP_IDLE;
					else if (service_ev)
						state_q <= CSP_SHIFT; // RULE_13 RULE_14 RULE_19
				end
				default:
					state_q <= CSP_IDLE;
			endcase
		end
	end

	// software service tracking; the block-end clear beats a same-cycle access, which still counts through serviced
	always_ff @(posedge clk_sys)
	begin
		if (reset || start_ev)
		begin
			serviced_q <= 1'b0;
			owed_q <= 1'b0;
		end
		else if (blk_end)
		begin
			serviced_q <= 1'b0;
			owed_q <= !serviced;
		end
		else if (service_ev)
		begin
			// the access that ends a wait is spent on that wait, not on the next block
			serviced_q <= (state_q != CSP_WAIT); // RULE_13 RULE_19
			owed_q <= 1'b0;
		end
	end

	// shift register: transmit on falling edge, receive on rising edge, lsb first
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			shift_q <= 8'h00;
			so_q <= 1'b1;
		end
		else if (fall_ev && is_tx)
		begin
			if (bit_q == 3'h0)
			begin
				shift_q <= tx_word; // RULE_11
				so_q <= tx_word[0]; // RULE_08
			end
			else
				so_q <= shift_q[bit_q]; // RULE_05
		end
		else if (rise_ev && !is_tx)
			shift_q[bit_q] <= serial_data_in; // RULE_06 RULE_08
	end

	// block-end interrupt: buffer empty on transmit, buffer full on receive
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			irq_q <= 1'b0;
		else
			irq_q <= blk_end && !rx_drop; // RULE_09 RULE_12 RULE_18
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = waitreq_q;
	assign serial_clock_pin_out = sck_q;
	assign serial_clock_pin_oe = sck_oe_q;
	assign serial_data_out = so_q;
	assign word_block_irq = irq_q;

endmodule

`default_nettype wire

// ===== tb/csp_checker.sv
// port-level assertions for the buffered clocked serial port
`timescale 1ns/1ns
`default_nettype none

module csp_checker
	import csp_pkg::*;
#(
	parameter int LOW_RATE_HALF = 8
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic serial_clock_pin_in,
	input wire logic serial_clock_pin_out,
	input wire logic serial_clock_pin_oe,
	input wire logic serial_data_out,
	input wire logic serial_data_in,
	input wire logic word_block_irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic pin_in_q;
	logic pin_out_q;
	logic [3:0] since_rise_q;

	////////////////////////////////////////////////////////////////////////////////
	// age of the last rising clock edge; saturates so it never wraps into a match
	always_ff @(posedge clk_sys)
	begin
		pin_in_q <= serial_clock_pin_in;
		pin_out_q <= serial_clock_pin_out;
		if (reset)
			since_rise_q <= 4'hF;
		else if ((serial_clock_pin_out && !pin_out_q) || (serial_clock_pin_in && !pin_in_q))
			since_rise_q <= 4'h0;
		else if (since_rise_q != 4'hF)
			since_rise_q <= since_rise_q + 4'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_bad_read;
		avs_read && avs_waitrequest && (avs_address > CSP_OFS_STATUS);
	endsequence
	sequence s_ctl1_write;
		avs_write && avs_waitrequest && avs_byteenable[0] && (avs_address == CSP_OFS_CTRL_ONE);
	endsequence

	a_bus_answer: assert property (s_req |=> !avs_waitrequest)
		else $error("waitrequest stayed high after a request");
	a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_bus_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest dropped with no request");
	a_unmapped_zero: assert property (s_bad_read |=> avs_readdata == 32'h0)
		else $error("unmapped read returned nonzero data");
	a_reset_idle: assert property ($fell(reset) |-> serial_clock_pin_out && serial_data_out && !word_block_irq)
		else $error("port not idle after reset");
	a_rise_stable: assert property ($rose(serial_clock_pin_out) && serial_clock_pin_oe |-> $stable(serial_data_out))
		else $error("transmit data moved on a rising clock edge");
	a_irq_pulse: assert property (word_block_irq |=> !word_block_irq)
		else $error("block interrupt longer than one cycle");
	a_irq_after_rise: assert property (word_block_irq |-> since_rise_q <= 4'h3 || (serial_clock_pin_out && !pin_out_q))
		else $error("block interrupt not tied to a final rising edge");
	a_abort_idle: assert property ((s_ctl1_write and avs_writedata[CSP_C1_ABORT]) |-> ##[1:3] serial_clock_pin_out ##1 serial_clock_pin_out [*4])
		else $error("clock pin not idle after abort");
	a_ext_select: assert property ((s_ctl1_write and (avs_writedata[2:0] == CSP_CLK_EXT)) |-> ##3 !serial_clock_pin_oe)
		else $error("clock pin still driven with external clock");
endmodule

bind csp_top csp_checker #(.LOW_RATE_HALF(LOW_RATE_HALF)) u_csp_checker (
	.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_out(serial_clock_pin_out),
	.serial_clock_pin_oe(serial_clock_pin_oe), .serial_data_out(serial_data_out),
	.serial_data_in(serial_data_in), .word_block_irq(word_block_irq));
`default_nettype wire

// ===== tb/csp_peer.sv
// behavioural serial peripheral: feeds receive bits and collects transmit bits
`timescale 1ns/1ns
`default_nettype none

module csp_peer
(
	input wire logic clk_sys,
	input wire logic sck,
	input wire logic sck_oe,
	input wire logic sdo,
	input wire logic load,
	input wire logic [63:0] send_word,
	input wire logic [7:0] pulses,
	output logic sdi,
	output logic [63:0] got,
	output logic ext_sck
);
	logic lc;
	logic lc_q;
	logic [1:0] div_q;
	logic [7:0] left_q;
	logic [63:0] send_q;

	// the line that clocks the link: the port's pin, or our own clock when it listens
	assign lc = sck_oe ? sck : ext_sck;

	////////////////////////////////////////////////////////////////////////////////
	// own clock: four cycles per level, a set number of pulses, parked high between frames
	always_ff @(posedge clk_sys)
	begin
		if (load)
		begin
			left_q <= pulses;
			div_q <= 2'h0;
			ext_sck <= 1'b1;
		end
		else if (left_q != 8'h00)
		begin
			div_q <= div_q + 2'h1;
			if (div_q == 2'h3)
			begin
				ext_sck <= !ext_sck;
				if (!ext_sck)
					left_q <= left_q - 8'h01;
			end
		end
	end

	// next bit after each falling edge, transmit bits collected on each rising edge
	always_ff @(posedge clk_sys)
	begin
		lc_q <= lc;
		if (load)
		begin
			send_q <= send_word;
			sdi <= 1'b1;
			got <= 64'h0;
		end
		else
		begin
			if (lc_q && !lc)
			begin
				sdi <= send_q[0];
				send_q <= send_q >> 1;
			end
			if (!lc_q && lc)
				got <= {sdo, got[63:1]};
		end
	end
endmodule
`default_nettype wire

// ===== tb/csp_top_tb.sv
// self-checking bench for the buffered clocked serial port
`timescale 1ns/1ns
`default_nettype none

module csp_top_tb;
	import csp_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic pin_out, pin_oe, sdo, sdi, irq;
	logic peer_load = 1'b1;
	logic [7:0] pulses = 8'h00;
	logic ext_sck;
	logic [63:0] send_word = 64'h0;
	logic [63:0] got;
	logic [31:0] rd, w;
	logic [2:0] code;
	int n_mismatch = 0;
	int comparisons = 0;
	int seed = 12327;
	int i, m, nb;
	logic [7:0] exp_q[$];

	always #10 clk_sys = ~clk_sys;

	csp_top #(.LOW_RATE_HALF(8)) uut (
		.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.serial_clock_pin_in(ext_sck), .serial_clock_pin_out(pin_out),
		.serial_clock_pin_oe(pin_oe), .serial_data_out(sdo), .serial_data_in(sdi),
		.word_block_irq(irq));

	csp_peer peer (.clk_sys(clk_sys), .sck(pin_out), .sck_oe(pin_oe), .sdo(sdo),
		.load(peer_load), .send_word(send_word), .pulses(pulses), .sdi(sdi), .got(got),
		.ext_sck(ext_sck));

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// one Avalon transfer; request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (avs_waitrequest !== 1'b0 && k < 50);
		if (avs_waitrequest !== 1'b0)
		begin
			n_mismatch++;
			close_out();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// the interrupt is a one-cycle pulse, so it is looked at on every edge
	task automatic wait_irq();
		int k;
		for (k = 0; k < 3000 && irq !== 1'b1; k++)
			@(posedge clk_sys);
		if (irq !== 1'b1)
		begin
			n_mismatch++;
			close_out();
		end
		// the peer takes the block's last bit on this very edge; let it land
		@(posedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		peer_load <= 1'b0;
		@(posedge clk_sys);
		check({30'h0, pin_out, sdo}, 32'h3);
		bus(0, CSP_OFS_STATUS, 8'h00);
		check(rd, 32'h0);
		bus(0, 6'h2C, 8'h00);
		check(rd, 32'h0);
		// two-word internal-clock transmit, then wait and resume twice
		bus(1, CSP_OFS_CTRL_TWO, 8'h01);
		for (i = 0; i < 2; i++)
		begin
			w = $random(seed);
			exp_q.push_back(w[7:0]);
			bus(1, CSP_OFS_BUF_BASE + 6'(i * 4), w[7:0]);
		end
		bus(1, CSP_OFS_CTRL_ONE, 8'h85);
		for (i = 0; i < 2; i++)
		begin
			wait_irq();
			check({16'h0, got[63:48]}, {16'h0, exp_q[1], exp_q[0]});
			repeat (40) @(posedge clk_sys);
			bus(0, CSP_OFS_STATUS, 8'h00);
			check(rd & 32'hA0, 32'hA0);
			check({31'h0, pin_out}, 32'h1);
			bus(1, CSP_OFS_BUF_LAST, 8'h5A);
		end
		bus(1, CSP_OFS_CTRL_ONE, 8'h05);
		for (i = 0; i < 100 && rd !== 32'h0; i++)
			bus(0, CSP_OFS_STATUS, 8'h00);
		check(rd, 32'h0);
		// mode change to 4-bit transmit empties the buffer
		bus(1, CSP_OFS_CTRL_ONE, 8'h55);
		bus(0, CSP_OFS_BUF_BASE + 6'h04, 8'h00);
		check(rd, 32'h0);
		bus(1, CSP_OFS_CTRL_TWO, 8'h00);
		w = $random(seed);
		bus(1, CSP_OFS_BUF_BASE, w[7:0]);
		bus(1, CSP_OFS_CTRL_ONE, 8'h95);
		wait_irq();
		check({28'h0, got[63:60]}, {28'h0, w[3:0]});
		bus(1, CSP_OFS_CTRL_ONE, 8'h55);
		bus(0, CSP_OFS_CTRL_ONE, 8'h00);
		check(rd & 32'h40, 32'h0);
		bus(0, CSP_OFS_STATUS, 8'h00);
		check(rd, 32'h0);
		bus(1, CSP_OFS_CTRL_ONE, 8'h57);
		// three-word receive in both widths
		for (m = 0; m < 2; m++)
		begin
			nb = m ? 4 : 8;
			code = m ? CSP_MODE_RX4 : CSP_MODE_RX8;
			bus(1, CSP_OFS_CTRL_ONE, {2'b01, code, 3'h5});
			bus(1, CSP_OFS_CTRL_TWO, 8'h02);
			send_word <= {$random(seed), $random(seed)};
			peer_load <= 1'b1;
			@(posedge clk_sys);
			peer_load <= 1'b0;
			bus(1, CSP_OFS_CTRL_ONE, {2'b10, code, 3'h5});
			wait_irq();
			repeat (40) @(posedge clk_sys);
			check({31'h0, pin_out}, 32'h1);
			for (i = 0; i < 3; i++)
			begin
				bus(0, CSP_OFS_BUF_BASE + 6'(i * 4), 8'h00);
				check(rd, 32'((send_word >> (nb * i)) & (m ? 64'hF : 64'hFF)));
			end
			bus(1, CSP_OFS_CTRL_ONE, {2'b01, code, 3'h5});
		end
		// external clock, one word: transmit sends a dummy next, receive drops the overrun
		bus(1, CSP_OFS_CTRL_TWO, 8'h00);
		for (m = 0; m < 2; m++)
		begin
			code = m ? CSP_MODE_RX8 : CSP_MODE_TX8;
			bus(1, CSP_OFS_CTRL_ONE, {2'b01, code, CSP_CLK_EXT});
			w = $random(seed);
			bus(1, CSP_OFS_BUF_BASE, w[7:0]);
			bus(1, CSP_OFS_CTRL_ONE, {2'b10, code, CSP_CLK_EXT});
			send_word <= {$random(seed), $random(seed)};
			pulses <= 8'h10;
			peer_load <= 1'b1;
			@(posedge clk_sys);
			peer_load <= 1'b0;
			repeat (150) @(posedge clk_sys);
			bus(0, CSP_OFS_STATUS, 8'h00);
			check(rd, 32'h0);
			bus(0, CSP_OFS_BUF_BASE, 8'h00);
			if (m)
				check(rd, {24'h0, send_word[7:0]});
			else
				check({16'h0, got[63:48]}, {16'h0, CSP_DUMMY_WORD, w[7:0]});
		end
		close_out();
	end
endmodule
`default_nettype wire
